// *** shared/rxb_if.sv ***
// Interface carrying the shared expansion bus lines
`timescale 1ns/10ps
`default_nettype none
interface rxb_if;
    logic data_o;
    logic data_oe;
    logic jam_o;
    logic jam_oe;
    logic xclk_o;
    logic xclk_oe;
    logic frame_o;
    logic frame_oe;
    logic bus_req_n;
    logic bused_data;
    logic collision_flag;
    logic expansion_clock;
    logic frame_line;
    logic sole_grant_n;
    logic multi_active_n;

    modport device (
        output data_o, data_oe, jam_o, jam_oe, xclk_o, xclk_oe, frame_o, frame_oe, bus_req_n,
        input bused_data, collision_flag, expansion_clock, frame_line, sole_grant_n, multi_active_n
    );
    modport arbiter (
        input bus_req_n,
        output sole_grant_n, multi_active_n
    );
endinterface : rxb_if
`default_nettype wire

// *** shared/rxb_pkg.sv ***
// Package with constants and types for the repeater expansion bus
package rxb_pkg;
    localparam int RXB_CLK_PERIOD_NS = 50;
    localparam int RXB_XCLK_PERIOD_NS = 100;
    // Half period of the driven expansion_clock in master clock cycles (minimum one)
    localparam int RXB_XCLK_HALF_RAW = RXB_XCLK_PERIOD_NS / (2 * RXB_CLK_PERIOD_NS);
    localparam int RXB_XCLK_HALF = (RXB_XCLK_HALF_RAW < 1) ? 1 : RXB_XCLK_HALF_RAW;
    localparam logic RXB_MODE_SYNC = 1'b0;
    localparam logic RXB_MODE_ASYNC = 1'b1;
    localparam logic RXB_RST_REQ_N = 1'b1;
    localparam logic [2:0] RXB_SYNC_RST = 3'h0;

    typedef enum logic [1:0] {
        RXB_IDLE = 2'b00,
        RXB_OWNER = 2'b01,
        RXB_MULTI = 2'b11,
        RXB_FOLLOW = 2'b10
    } rxb_state_type;
endpackage : rxb_pkg

// *** src/rxb_arbiter.sv ***
// External arbiter end of the expansion bus for one request line view
`timescale 1ns/10ps
`default_nettype none
module rxb_arbiter (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [1:0] OTHER_REQ_N,
    output logic SOLE_GRANT,
    output logic MULTI_ACTIVE,
    rxb_if.arbiter BUS
);
    import rxb_pkg::*;

    logic [2:0] req;
    logic [1:0] cnt;
    logic ack_q;
    logic col_q;

    assign req = ~{OTHER_REQ_N, BUS.bus_req_n};

    always_comb begin
        cnt = 2'h0;
        for (int i = 0; i < 3; i++) begin
            if (req[i] && cnt != 2'h3) cnt = cnt + 2'h1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ack_q <= 1'b0;
            col_q <= 1'b0;
        end else begin
            ack_q <= (cnt == 2'h1);
            col_q <= (cnt >= 2'h2);
        end
    end

    assign BUS.sole_grant_n = ~ack_q;
    assign BUS.multi_active_n = ~col_q;
    assign SOLE_GRANT = ack_q;
    assign MULTI_ACTIVE = col_q;
endmodule : rxb_arbiter
`default_nettype wire

// *** src/rxb_device.sv ***
// Repeater expansion bus device end
`timescale 1ns/10ps
`default_nettype none
module rxb_device (
    input wire logic CLK,
    input wire logic RST,
    input wire logic BUS_MODE_SELECT,
    input wire logic PORT_ACTIVE,
    input wire logic PORT_DATA,
    input wire logic PORT_COLLISION,
    input wire logic PORT_MULTI,
    output logic REPEAT_DATA,
    output logic REPEAT_VALID,
    output logic JAM_OUT,
    output logic JAM_MULTIPORT,
    output logic BUS_MODE,
    rxb_if.device BUS
);
    import rxb_pkg::*;

    logic mode_q;
    logic req_q;
    logic [2:0] ack_s_q;
    logic [2:0] col_s_q;
    logic [2:0] jam_s_q;
    logic [2:0] bd_s_q;
    logic [2:0] eck_s_q;
    logic [2:0] frm_s_q;
    logic grant_l;
    logic multi_l;
    logic jam_l;
    logic bd_l;
    logic eck_l;
    logic frm_l;
    logic eck_prev_q;
    logic owner;
    logic [7:0] div_q;
    logic xclk_q;
    logic tx_data_q;
    logic tx_jam_q;
    logic tx_frm_q;
    logic rep_data_q;
    logic rep_val_q;
    logic jam_q;
    logic jmp_q;
    rxb_state_type state_q;
    rxb_state_type state_d;

    // Mode captured by a clocked process while reset is held
    always_ff @(posedge CLK) begin
        if (RST) begin
            mode_q <= BUS_MODE_SELECT;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            req_q <= 1'b0;
        end else begin
            req_q <= PORT_ACTIVE;
        end
    end

    // Three-stage synchronisers; a change counts when stages two and three agree
    always_ff @(posedge CLK) begin
        if (RST) begin
            ack_s_q <= RXB_SYNC_RST;
            col_s_q <= RXB_SYNC_RST;
            jam_s_q <= RXB_SYNC_RST;
            bd_s_q <= RXB_SYNC_RST;
            eck_s_q <= RXB_SYNC_RST;
            frm_s_q <= RXB_SYNC_RST;
        end else begin
            ack_s_q <= {ack_s_q[1:0], ~BUS.sole_grant_n};
            col_s_q <= {col_s_q[1:0], ~BUS.multi_active_n};
            jam_s_q <= {jam_s_q[1:0], BUS.collision_flag};
            bd_s_q <= {bd_s_q[1:0], BUS.bused_data};
            eck_s_q <= {eck_s_q[1:0], BUS.expansion_clock};
            frm_s_q <= {frm_s_q[1:0], BUS.frame_line};
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            grant_l <= 1'b0;
            multi_l <= 1'b0;
            jam_l <= 1'b0;
            bd_l <= 1'b0;
            eck_l <= 1'b0;
            frm_l <= 1'b0;
        end else begin
            if (ack_s_q[1] == ack_s_q[2]) grant_l <= ack_s_q[2];
            if (col_s_q[1] == col_s_q[2]) multi_l <= col_s_q[2];
            if (jam_s_q[1] == jam_s_q[2]) jam_l <= jam_s_q[2];
            if (bd_s_q[1] == bd_s_q[2]) bd_l <= bd_s_q[2];
            if (eck_s_q[1] == eck_s_q[2]) eck_l <= eck_s_q[2];
            if (frm_s_q[1] == frm_s_q[2]) frm_l <= frm_s_q[2];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            eck_prev_q <= 1'b0;
        end else begin
            eck_prev_q <= eck_l;
        end
    end

    assign owner = req_q && grant_l;

    always_comb begin
        state_d = RXB_IDLE;
        case (state_q)
            RXB_IDLE, RXB_OWNER, RXB_MULTI, RXB_FOLLOW: begin
                if (multi_l) begin
                    state_d = RXB_MULTI;
                end else if (owner) begin
                    state_d = RXB_OWNER;
                end else if (jam_l) begin
                    state_d = RXB_FOLLOW;
                end else begin
                    state_d = RXB_IDLE;
                end
            end
            default: state_d = RXB_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= RXB_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Expansion clock divider, only runs while owning the bus in async mode
    always_ff @(posedge CLK) begin
        if (RST || !owner || mode_q == RXB_MODE_SYNC) begin
            div_q <= 8'h00;
            xclk_q <= 1'b0;
        end else if (div_q == 8'(RXB_XCLK_HALF - 1)) begin
            div_q <= 8'h00;
            xclk_q <= ~xclk_q;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // Transmit data: per master clock in sync mode, per rising expansion_clock in async
    always_ff @(posedge CLK) begin
        if (RST) begin
            tx_data_q <= 1'b0;
            tx_jam_q <= 1'b0;
            tx_frm_q <= 1'b0;
        end else if (mode_q == RXB_MODE_SYNC || (xclk_q == 1'b0 && div_q == 8'(RXB_XCLK_HALF - 1))) begin
            tx_jam_q <= PORT_COLLISION;
            tx_frm_q <= owner && PORT_ACTIVE;
            if (PORT_COLLISION) begin
                tx_data_q <= ~PORT_MULTI;
            end else begin
                tx_data_q <= PORT_DATA;
            end
        end
    end

    // Receive path repeats bus data; async samples on expansion_clock rise
    always_ff @(posedge CLK) begin
        if (RST) begin
            rep_data_q <= 1'b0;
            rep_val_q <= 1'b0;
        end else if (!owner && (mode_q == RXB_MODE_SYNC || (eck_l && !eck_prev_q))) begin
            rep_data_q <= bd_l;
            rep_val_q <= grant_l && (mode_q == RXB_MODE_SYNC || frm_l);
        end else begin
            rep_val_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            jam_q <= 1'b0;
            jmp_q <= 1'b0;
        end else begin
            case (state_q)
                RXB_MULTI: begin
                    jam_q <= 1'b1;
                    jmp_q <= 1'b1;
                end
                RXB_FOLLOW: begin
                    jam_q <= 1'b1;
                    jmp_q <= ~bd_l;
                end
                RXB_OWNER: begin
                    jam_q <= PORT_COLLISION;
                    jmp_q <= PORT_COLLISION && PORT_MULTI;
                end
                default: begin
                    jam_q <= 1'b0;
                    jmp_q <= 1'b0;
                end
            endcase
        end
    end

    assign BUS.bus_req_n = ~req_q;
    assign BUS.data_o = tx_data_q;
    assign BUS.data_oe = owner;
    assign BUS.jam_o = tx_jam_q;
    assign BUS.jam_oe = owner;
    assign BUS.xclk_o = xclk_q;
    assign BUS.xclk_oe = owner && mode_q == RXB_MODE_ASYNC;
    assign BUS.frame_o = tx_frm_q;
    assign BUS.frame_oe = owner && mode_q == RXB_MODE_ASYNC;
    assign REPEAT_DATA = rep_data_q;
    assign REPEAT_VALID = rep_val_q;
    assign JAM_OUT = jam_q;
    assign JAM_MULTIPORT = jmp_q;
    assign BUS_MODE = mode_q;
endmodule : rxb_device
`default_nettype wire

// *** verif/repeater_expansion_bus_test.sv ***
// Testbench joining device and arbiter over the expansion bus
`timescale 1ns/10ps
`default_nettype none
module repeater_expansion_bus_test;
    logic clk, rst, msel, act, pdat, pcol, pmul, tog, pd, pj, pe, pf, poe, pc, pm, xd;
    logic rdat, rval, jam, jmul, mode, sg, ma;
    logic [1:0] oreq;
    logic [31:0] seed;
    int fails, n_checks, k;
    logic q[$];
    rxb_if b();
    assign b.bused_data = b.data_oe ? b.data_o : poe ? pd : tog;
    assign b.collision_flag = b.jam_oe ? b.jam_o : poe ? pj : tog;
    assign b.expansion_clock = b.xclk_oe ? b.xclk_o : pe;
    assign b.frame_line = b.frame_oe ? b.frame_o : pf;
    rxb_device u_rxb_device (.CLK(clk), .RST(rst), .BUS_MODE_SELECT(msel), .PORT_ACTIVE(act), .PORT_DATA(pdat),
        .PORT_COLLISION(pcol), .PORT_MULTI(pmul), .REPEAT_DATA(rdat), .REPEAT_VALID(rval), .JAM_OUT(jam),
        .JAM_MULTIPORT(jmul), .BUS_MODE(mode), .BUS(b.device));
    rxb_arbiter u_rxb_arbiter (.CLK(clk), .RST(rst), .OTHER_REQ_N(oreq), .SOLE_GRANT(sg), .MULTI_ACTIVE(ma),
        .BUS(b.arbiter));
    rxb_properties u_rxb_properties (.CLK(clk), .RST(rst), .OTHER_REQ_N(oreq), .PORT_DATA(pdat),
        .PORT_COLLISION(pcol), .PORT_MULTI(pmul), .data_o(b.data_o), .data_oe(b.data_oe), .jam_o(b.jam_o),
        .jam_oe(b.jam_oe), .xclk_o(b.xclk_o), .xclk_oe(b.xclk_oe), .bus_req_n(b.bus_req_n),
        .sole_grant_n(b.sole_grant_n), .multi_active_n(b.multi_active_n));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task do_reset(input logic m);
        rst = 1'b1;
        msel = m;
        repeat (16) @(negedge clk);
        rst = 1'b0;
    endtask : do_reset
    task results;
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) tog <= ~tog;
    // Async receive model: each framed rising bus clock edge delivers the next queued bit
    always @(posedge clk) begin
        if (mode === 1'b1 && poe && rval === 1'b1 && q.size() > 0) begin
            check(rdat, q.pop_front());
        end
    end
    initial begin
        #2_000_000;
        fails++;
        results();
    end
    initial begin
        {tog, act, pdat, pcol, pmul, pd, pj, pe, pf, poe, pc, pm} = '0;
        oreq = 2'b11;
        seed = 32'h8580;
        do_reset(1'b0);
        check(mode, 1'b0);
        act = 1'b1;
        for (k = 0; k < 30 && b.data_oe !== 1'b1; k++) @(negedge clk);
        check(sg, 1'b1);
        check(b.bus_req_n, 1'b0);
        for (k = 0; k < 40; k++) begin
            @(negedge clk);
            check(b.bused_data, pc ? !pm : pdat);
            check(b.collision_flag, pc);
            seed = xs(seed);
            pdat = seed[0];
            pm = seed[1];
            pc = (k > 24);
            pcol = pc;
            pmul = pm;
        end
        pcol = 1'b0;
        oreq = 2'b10;
        repeat (2) @(negedge clk);
        check(ma, 1'b1);
        check(sg, 1'b0);
        for (k = 0; k < 20 && jmul !== 1'b1; k++) @(negedge clk);
        check({jam, jmul}, 2'b11);
        oreq = 2'b11;
        for (k = 0; k < 30 && b.data_oe !== 1'b1; k++) @(negedge clk);
        check(b.data_oe, 1'b1);
        act = 1'b0;
        oreq = 2'b10;
        repeat (10) @(negedge clk);
        poe = 1'b1;
        for (k = 0; k < 8; k++) begin
            seed = xs(seed);
            pd = seed[2];
            pj = (k > 5);
            repeat (8) @(negedge clk);
            check({b.data_oe, b.jam_oe}, 2'b00);
            check({b.bus_req_n, rval}, 2'b11);
            if (pj) check({jam, jmul}, {1'b1, !pd});
            else check(rdat, pd);
        end
        {poe, pj, act} = '0;
        oreq = 2'b11;
        do_reset(1'b1);
        check(mode, 1'b1);
        msel = 1'b0;
        act = 1'b1;
        for (k = 0; k < 30 && b.xclk_oe !== 1'b1; k++) @(negedge clk);
        repeat (2) @(negedge clk);
        check(b.frame_line, 1'b1);
        act = 1'b0;
        oreq = 2'b10;
        repeat (12) @(negedge clk);
        check({jam, jmul, b.xclk_oe}, 3'b000);
        {poe, pf} = 2'b11;
        for (k = 0; k < 8; k++) begin
            seed = xs(seed);
            pd = seed[3];
            #200 pe = 1'b1;
            q.push_back(pd);
            #200 pe = 1'b0;
        end
        repeat (8) @(negedge clk);
        check(q.size(), 0);
        check(mode, 1'b1);
        results();
    end
endmodule : repeater_expansion_bus_test
`default_nettype wire

// *** verif/rxb_properties.sv ***
// Concurrent checks on the expansion bus between device and arbiter
`timescale 1ns/10ps
`default_nettype none
module rxb_properties (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [1:0] OTHER_REQ_N,
    input wire logic PORT_DATA,
    input wire logic PORT_COLLISION,
    input wire logic PORT_MULTI,
    input wire logic data_o,
    input wire logic data_oe,
    input wire logic jam_o,
    input wire logic jam_oe,
    input wire logic xclk_o,
    input wire logic xclk_oe,
    input wire logic bus_req_n,
    input wire logic sole_grant_n,
    input wire logic multi_active_n
);
    logic [1:0] reqs;
    assign reqs = 2'(!bus_req_n) + 2'(!OTHER_REQ_N[0]) + 2'(!OTHER_REQ_N[1]);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    chk_grant_one: assert property (1 |=> sole_grant_n == ($past(reqs) != 2'h1))
        else $error("grant does not match request count");
    chk_multi_flag: assert property (1 |=> multi_active_n == ($past(reqs) < 2'h2))
        else $error("multi flag does not match request count");
    chk_data_nrz: assert property (!sole_grant_n [*6] ##0 data_oe && !xclk_oe && $past(data_oe)
        && !$past(PORT_COLLISION) |-> data_o == $past(PORT_DATA)) else $error("bus data not previous bit");
    chk_jam_level: assert property (!sole_grant_n [*6] ##0 jam_oe && $past(jam_oe)
        |-> jam_o == $past(PORT_COLLISION)) else $error("collision flag does not follow collision");
    chk_jam_code: assert property (!sole_grant_n [*6] ##0 data_oe && jam_o && $past(data_oe)
        |-> data_o == !$past(PORT_MULTI)) else $error("collision kind code wrong");
    chk_drive_req: assert property (data_oe || jam_oe |-> !$past(bus_req_n))
        else $error("bus driven without request");
    chk_undriven: assert property (sole_grant_n [*6] |-> !data_oe && !jam_oe && !xclk_oe)
        else $error("bus driven without grant");
    chk_xclk_rate: assert property (xclk_oe && $past(xclk_oe) |-> xclk_o != $past(xclk_o))
        else $error("bus clock not toggling each cycle");
    chk_xclk_own: assert property (xclk_oe |-> !$past(bus_req_n) && !$past(sole_grant_n))
        else $error("bus clock driven while not owner");
endmodule : rxb_properties
`default_nettype wire
